// file: nsrc_pkg.sv
package nsrc_pkg;

    // ----------------------------------------------------------------
    // widths
    // ----------------------------------------------------------------
    localparam int ADDR_W = 20;
    localparam int DATA_W = 8;
    localparam int TMR_W = 32;

    // ----------------------------------------------------------------
    // apb register map, byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_ADDR = 8'h04;
    localparam logic [7:0] OFF_WDATA = 8'h08;
    localparam logic [7:0] OFF_RDATA = 8'h0c;
    localparam logic [7:0] OFF_STATUS = 8'h10;

    // status field positions
    localparam int ST_BUSY = 0;
    localparam int ST_DEV_BUSY = 1;
    localparam int ST_DIRTY = 2;
    localparam int ST_AUTOSTORE = 3;
    localparam int ST_REJECT = 4;

    // reset values of the mirrored device state
    localparam logic DIRTY_RST = 1'b0;
    localparam logic AUTOSTORE_RST = 1'b1;

    // ----------------------------------------------------------------
    // commands written to ctrl[2:0]
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        CMD_NONE = 3'b000,
        CMD_READ = 3'b001,
        CMD_WRITE = 3'b010,
        CMD_HW_STORE = 3'b011,
        CMD_SW_STORE = 3'b100,
        CMD_SW_RECALL = 3'b101,
        CMD_AS_DISABLE = 3'b110,
        CMD_AS_ENABLE = 3'b111
    } nsrc_cmd_t;

    // ----------------------------------------------------------------
    // mode-change read sequence addresses
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] SEQ_A0 = 20'h04e38;
    localparam logic [ADDR_W-1:0] SEQ_A1 = 20'h0b1c7;
    localparam logic [ADDR_W-1:0] SEQ_A2 = 20'h083e0;
    localparam logic [ADDR_W-1:0] SEQ_A3 = 20'h07c1f;
    localparam logic [ADDR_W-1:0] SEQ_A4 = 20'h0703f;
    localparam logic [ADDR_W-1:0] SEQ_STORE = 20'h08fc0;
    localparam logic [ADDR_W-1:0] SEQ_RECALL = 20'h04c63;
    localparam logic [ADDR_W-1:0] SEQ_AS_OFF = 20'h08b45;
    localparam logic [ADDR_W-1:0] SEQ_AS_ON = 20'h04b46;
    localparam logic [2:0] SEQ_LAST = 3'h5;

    // ----------------------------------------------------------------
    // timing, in ns, and derived cycle counts at 20 mhz
    // ----------------------------------------------------------------
    localparam int CLK_NS = 50;
    localparam int T_STROBE_NS = 100;
    localparam int T_GAP_NS = 50;
    localparam int T_SETTLE_NS = 100;
    localparam int STORE_GRACE_NS = 25000;
    localparam int STORE_DURATION_NS = 10000000;
    localparam int RECALL_DURATION_NS = 200000;
    localparam int HW_RECALL_DURATION_NS = 20000000;

    localparam int STROBE_CYC = (T_STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int GAP_CYC = (T_GAP_NS + CLK_NS - 1) / CLK_NS;
    localparam int SETTLE_CYC = (T_SETTLE_NS + CLK_NS - 1) / CLK_NS;

endpackage

// file: nsrc_timer.sv
`timescale 1ns/1ps
// down counter: after a load of n it reports done n cycles later
module nsrc_timer #(
    parameter int TW = 32,
    parameter logic [TW-1:0] INIT = '0
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic load,
    input wire logic [TW-1:0] load_val,
    output logic done
);
    logic [TW-1:0] cnt_reg;

    // reload wins over counting; holds at zero
    always_ff @(posedge mclk)
    begin
        if (rst)
            cnt_reg <= INIT;
        else if (load)
            cnt_reg <= load_val;
        else if (cnt_reg != '0)
            cnt_reg <= cnt_reg - TW'(1);
    end

    assign done = (cnt_reg == '0);
endmodule

// file: nsrc_host.sv
`timescale 1ns/1ps
// Operation
// R01: host pulls store pin low to request store
// R02: device stores on request only if dirty
// R03: device holds store pin low while busy
// R04: device serves accesses during store grace time
// R05: writes after store pin low are blocked
// R06: device latches recall at power-up
// R07: device recalls automatically when supply returns
// R08: six exact reads start software store
// R09: store erases then programs nonvolatile cells
// R10: store disables memory until store duration
// R11: host issues sequence accesses as oe reads
// R12: five reads plus 0x04c63 start recall
// R13: recall clears then copies, access after duration
// R14: each controlling falling edge clean, no doubles
// R15: low supply refuses stores and writes
// R16: write held low at event needs new edge
// R17: power-down returns auto-store to enabled
// R18: boot firmware rewrites auto-store setting each power-up; host only resets its mirror to enabled and sends no sequence
// R19: only lower 16 address bits matched
// R20: software store ignores the dirty condition
// R21: five reads plus 0x08b45 clear auto-store
// R22: five reads plus 0x04b46 set auto-store
// R23: mismatch or write restarts sequence detector
// R24: dirty flag set by write, cleared by store
module nsrc_host
    import nsrc_pkg::*;
#(
    parameter int GRACE_CYC = (STORE_GRACE_NS + CLK_NS - 1) / CLK_NS,
    parameter int STORE_CYC = (STORE_DURATION_NS + CLK_NS - 1) / CLK_NS,
    parameter int RECALL_CYC = (RECALL_DURATION_NS + CLK_NS - 1) / CLK_NS,
    parameter int HW_RECALL_CYC = (HW_RECALL_DURATION_NS + CLK_NS - 1) / CLK_NS
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [nsrc_pkg::ADDR_W-1:0] mem_addr,
    output logic mem_ce_n,
    output logic mem_oe_n,
    output logic mem_we_n,
    input wire logic [nsrc_pkg::DATA_W-1:0] dq_in,
    output logic [nsrc_pkg::DATA_W-1:0] dq_out,
    output logic dq_oe,
    input wire logic store_request_busy_n_in,
    output logic store_request_busy_n_out,
    output logic store_request_busy_n_oe
);
    import nsrc_pkg::*;

    typedef enum logic [3:0] {
        S_BOOT = 4'b0000,
        S_IDLE = 4'b0001,
        S_SETUP = 4'b0010,
        S_STROBE = 4'b0011,
        S_GAP = 4'b0100,
        S_HSB_PULL = 4'b0101,
        S_HSB_SETTLE = 4'b0110,
        S_HSB_WAIT = 4'b0111,
        S_NV_WAIT = 4'b1000
    } nsrc_state_t;

    nsrc_state_t state_reg, state_next;
    nsrc_cmd_t cmd_reg;
    logic [2:0] step_reg, step_next;
    logic pend_reg, reject_reg, dirty_reg, autostore_reg, busy_seen_reg;
    logic [ADDR_W-1:0] addr_reg, mem_addr_reg;
    logic [DATA_W-1:0] wdata_reg, rdata_reg, dq_out_reg;
    logic [31:0] prdata_reg;
    logic pready_reg, pslverr_reg;
    logic ce_n_reg, oe_n_reg, we_n_reg, dq_oe_reg, hsb_oe_reg, hsb_out_reg;
    logic t_load, t_done, is_seq, is_write, apb_fire, apb_setup;
    logic [TMR_W-1:0] t_val;
    logic [31:0] rd_mux;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // address of sequence step n for the command in flight
    function automatic logic [ADDR_W-1:0] seq_addr(input logic [2:0] n, input nsrc_cmd_t c);
        logic [ADDR_W-1:0] a;
        a = SEQ_A0;
        unique case (n)
            3'h0: a = SEQ_A0;
            3'h1: a = SEQ_A1;
            3'h2: a = SEQ_A2;
            3'h3: a = SEQ_A3;
            3'h4: a = SEQ_A4;
            default:
            begin
                if (c == CMD_SW_STORE)
                    a = SEQ_STORE;
                else if (c == CMD_SW_RECALL)
                    a = SEQ_RECALL;
                else if (c == CMD_AS_DISABLE)
                    a = SEQ_AS_OFF;
                else
                    a = SEQ_AS_ON;
            end
        endcase
        return a;
    endfunction

    assign is_seq = (cmd_reg == CMD_SW_STORE) || (cmd_reg == CMD_SW_RECALL)
                    || (cmd_reg == CMD_AS_DISABLE) || (cmd_reg == CMD_AS_ENABLE);
    assign is_write = (cmd_reg == CMD_WRITE);
    assign apb_setup = psel && penable && !pready_reg;
    assign apb_fire = psel && penable && pready_reg;

    // long waits run off one shared counter; boot wait preloaded at reset
    nsrc_timer #(
        .TW(TMR_W),
        .INIT(TMR_W'(HW_RECALL_CYC - 1))
    ) u_timer (
        .mclk(mclk),
        .rst(rst),
        .load(t_load),
        .load_val(t_val),
        .done(t_done)
    );

    // ----------------------------------------------------------------
    // apb slave
    // ----------------------------------------------------------------
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        unique case (paddr)
            OFF_CTRL: rd_mux = {29'h0, cmd_reg};
            OFF_ADDR: rd_mux = {12'h000, addr_reg};
            OFF_WDATA: rd_mux = {24'h00_0000, wdata_reg};
            OFF_RDATA: rd_mux = {24'h00_0000, rdata_reg};
            OFF_STATUS:
            begin
                rd_mux[ST_BUSY] = pend_reg || (state_reg != S_IDLE);
                rd_mux[ST_DEV_BUSY] = !store_request_busy_n_in;
                rd_mux[ST_DIRTY] = dirty_reg;
                rd_mux[ST_AUTOSTORE] = autostore_reg;
                rd_mux[ST_REJECT] = reject_reg;
            end
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // one wait state; unmapped offsets answer with pslverr
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end
        else
        begin
            pready_reg <= apb_setup;
            if (apb_setup)
            begin
                prdata_reg <= pwrite ? 32'h0000_0000 : rd_mux;
                pslverr_reg <= (paddr != OFF_CTRL) && (paddr != OFF_ADDR)
                               && (paddr != OFF_WDATA) && (paddr != OFF_RDATA)
                               && (paddr != OFF_STATUS);
            end
        end
    end

    // address and write data registers, written in any state
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            addr_reg <= '0;
            wdata_reg <= '0;
        end
        else if (apb_fire && pwrite)
        begin
            if (paddr == OFF_ADDR)
                addr_reg <= pwdata[ADDR_W-1:0];
            if (paddr == OFF_WDATA)
                wdata_reg <= pwdata[DATA_W-1:0];
        end
    end

    // command pending; a command while busy is refused and flagged
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            cmd_reg <= CMD_NONE;
            pend_reg <= 1'b0;
            reject_reg <= 1'b0;
        end
        else
        begin
            if (apb_fire && pwrite && paddr == OFF_CTRL && pwdata[2:0] != CMD_NONE)
            begin
                if (pend_reg || state_reg != S_IDLE)
                    reject_reg <= 1'b1;
                else
                begin
                    cmd_reg <= nsrc_cmd_t'(pwdata[2:0]);
                    pend_reg <= 1'b1;
                end
            end
            else if (apb_fire && pwrite && paddr == OFF_STATUS && pwdata[ST_REJECT])
                reject_reg <= 1'b0;
            if (state_reg == S_IDLE && state_next != S_IDLE)
                pend_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        step_next = step_reg;
        t_load = 1'b0;
        t_val = '0;
        unique case (state_reg)
            S_BOOT:
                if (t_done)
                    state_next = S_IDLE; // R07
            S_IDLE:
                // device busy low holds off every start
                if (pend_reg && store_request_busy_n_in) // R03
                begin
                    step_next = 3'h0;
                    t_load = 1'b1;
                    if (cmd_reg == CMD_HW_STORE)
                    begin
                        state_next = S_HSB_PULL; // R01
                        t_val = TMR_W'(GRACE_CYC - 1);
                    end
                    else
                        state_next = S_SETUP;
                end
            S_SETUP:
            begin
                state_next = S_STROBE;
                t_load = 1'b1;
                t_val = TMR_W'(STROBE_CYC - 1);
            end
            S_STROBE:
                if (t_done)
                begin
                    state_next = S_GAP;
                    t_load = 1'b1;
                    t_val = TMR_W'(GAP_CYC - 1);
                end
            S_GAP:
                if (t_done)
                begin
                    if (is_seq && step_reg != SEQ_LAST)
                    begin
                        state_next = S_SETUP; // R08 R12
                        step_next = step_reg + 3'h1;
                    end
                    else if (cmd_reg == CMD_SW_STORE || cmd_reg == CMD_SW_RECALL)
                    begin
                        state_next = S_NV_WAIT; // R10 R13
                        t_load = 1'b1;
                        t_val = (cmd_reg == CMD_SW_STORE) ? TMR_W'(STORE_CYC - 1)
                                                          : TMR_W'(RECALL_CYC - 1);
                    end
                    else
                        state_next = S_IDLE;
                end
            S_HSB_PULL:
                if (t_done)
                begin
                    state_next = S_HSB_SETTLE;
                    t_load = 1'b1;
                    t_val = TMR_W'(SETTLE_CYC - 1);
                end
            S_HSB_SETTLE:
                if (t_done)
                    state_next = S_HSB_WAIT;
            S_HSB_WAIT:
                if (store_request_busy_n_in)
                    state_next = S_IDLE; // R03
            S_NV_WAIT:
                if (t_done)
                    state_next = S_IDLE;
            default:
                state_next = S_IDLE;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            state_reg <= S_BOOT;
            step_reg <= 3'h0;
        end
        else
        begin
            state_reg <= state_next;
            step_reg <= step_next;
        end
    end

    // ----------------------------------------------------------------
    // memory pins
    // ----------------------------------------------------------------
    // strobes idle high between cycles so every access gets a fresh edge
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            mem_addr_reg <= '0;
            ce_n_reg <= 1'b1;
            oe_n_reg <= 1'b1;
            we_n_reg <= 1'b1;
            dq_oe_reg <= 1'b0;
            dq_out_reg <= '0;
            hsb_oe_reg <= 1'b0;
            hsb_out_reg <= 1'b0;
        end
        else
        begin
            ce_n_reg <= !(state_next == S_STROBE); // R14 R16
            oe_n_reg <= !(state_next == S_STROBE && !is_write); // R11
            we_n_reg <= !(state_next == S_STROBE && is_write);
            dq_oe_reg <= (state_next == S_STROBE && is_write);
            hsb_oe_reg <= (state_next == S_HSB_PULL); // R01
            if (state_next == S_SETUP)
                mem_addr_reg <= is_seq ? seq_addr(step_next, cmd_reg) : addr_reg; // R08 R12 R21 R22
            dq_out_reg <= wdata_reg;
        end
    end

    // read data taken on the last strobe cycle
    always_ff @(posedge mclk)
    begin
        if (rst)
            rdata_reg <= '0;
        else if (state_reg == S_STROBE && t_done && cmd_reg == CMD_READ)
            rdata_reg <= dq_in;
    end

    // ----------------------------------------------------------------
    // mirrored device state
    // ----------------------------------------------------------------
    // the device may drop a hardware store; for it only a seen busy clears dirty
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            dirty_reg <= DIRTY_RST;
            autostore_reg <= AUTOSTORE_RST; // R17
            busy_seen_reg <= 1'b0;
        end
        else
        begin
            if (state_reg == S_IDLE)
                busy_seen_reg <= 1'b0;
            else if (state_reg == S_HSB_SETTLE || state_reg == S_HSB_WAIT)
                busy_seen_reg <= busy_seen_reg || !store_request_busy_n_in;
            if (state_reg == S_STROBE && is_write)
                dirty_reg <= 1'b1; // R24
            else if (state_reg == S_NV_WAIT && t_done)
                dirty_reg <= 1'b0; // R24
            else if (state_reg == S_HSB_WAIT && store_request_busy_n_in && busy_seen_reg)
                dirty_reg <= 1'b0; // R02
            if (state_reg == S_GAP && t_done && step_reg == SEQ_LAST)
            begin
                if (cmd_reg == CMD_AS_DISABLE)
                    autostore_reg <= 1'b0; // R21
                else if (cmd_reg == CMD_AS_ENABLE)
                    autostore_reg <= 1'b1; // R22
            end
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign mem_addr = mem_addr_reg;
    assign mem_ce_n = ce_n_reg;
    assign mem_oe_n = oe_n_reg;
    assign mem_we_n = we_n_reg;
    assign dq_out = dq_out_reg;
    assign dq_oe = dq_oe_reg;
    assign store_request_busy_n_out = hsb_out_reg;
    assign store_request_busy_n_oe = hsb_oe_reg;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_seq_is_read;
        @(posedge mclk) disable iff (rst) (!mem_ce_n && is_seq) |-> (mem_we_n && !mem_oe_n);
    endproperty
    a_seq_is_read: assert property (p_seq_is_read) else $error("sequence access not a read"); // R11

    property p_seq_addr;
        @(posedge mclk) disable iff (rst)
            (!mem_ce_n && is_seq) |-> (mem_addr[15:0] == 16'(seq_addr(step_reg, cmd_reg)));
    endproperty
    a_seq_addr: assert property (p_seq_addr) else $error("sequence address wrong"); // R08

    property p_store_final;
        @(posedge mclk) disable iff (rst)
            (!mem_ce_n && cmd_reg == CMD_SW_STORE && step_reg == SEQ_LAST)
            |-> (mem_addr == SEQ_STORE);
    endproperty
    a_store_final: assert property (p_store_final) else $error("store final address wrong"); // R08

    property p_clean_edge;
        @(posedge mclk) disable iff (rst) $fell(mem_ce_n) |=> !mem_ce_n;
    endproperty
    a_clean_edge: assert property (p_clean_edge) else $error("chip select glitch"); // R14

    property p_hsb_hold;
        @(posedge mclk) disable iff (rst) $rose(store_request_busy_n_oe) |-> store_request_busy_n_oe[*8];
    endproperty
    a_hsb_hold: assert property (p_hsb_hold) else $error("store request too short"); // R01

    property p_no_write_in_store;
        @(posedge mclk) disable iff (rst) store_request_busy_n_oe |-> (mem_we_n && mem_ce_n);
    endproperty
    a_no_write_in_store: assert property (p_no_write_in_store) else $error("access during request"); // R05

    property p_nv_quiet;
        @(posedge mclk) disable iff (rst) (state_reg == S_NV_WAIT) |-> (mem_ce_n && mem_we_n && !dq_oe);
    endproperty
    a_nv_quiet: assert property (p_nv_quiet) else $error("access during store or recall"); // R10

    property p_boot_quiet;
        @(posedge mclk) disable iff (rst) (state_reg == S_BOOT) |-> (mem_ce_n && mem_we_n);
    endproperty
    a_boot_quiet: assert property (p_boot_quiet) else $error("access during power-up recall"); // R07

    property p_as_off;
        @(posedge mclk) disable iff (rst)
            (state_reg == S_GAP && t_done && step_reg == SEQ_LAST && cmd_reg == CMD_AS_DISABLE)
            |=> !autostore_reg;
    endproperty
    a_as_off: assert property (p_as_off) else $error("auto-store mirror not cleared"); // R21

    property p_apb_answer;
        @(posedge mclk) disable iff (rst) (psel && penable && !pready) |=> pready;
    endproperty
    a_apb_answer: assert property (p_apb_answer) else $error("apb answer late");
endmodule

// file: nsrc_dev_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// nv sram stand-in, stepped on mclk
// ----------------------------------------
module nsrc_dev_model
    import nsrc_pkg::*;
#(
    parameter int BUSY_CYC = 30
) (
    input wire logic mclk,
    input wire logic [19:0] mem_addr,
    input wire logic mem_ce_n,
    input wire logic mem_oe_n,
    input wire logic mem_we_n,
    input wire logic [7:0] dq_out,
    input wire logic host_pull,
    output logic [7:0] dq_in,
    output logic busy_drive
);
    localparam logic [79:0] LEADS = {SEQ_A4[15:0], SEQ_A3[15:0],
        SEQ_A2[15:0], SEQ_A1[15:0], SEQ_A0[15:0]};
    logic [7:0] sram [logic [19:0]];
    logic [7:0] nv [logic [19:0]];
    logic [7:0] last_reg = 8'h00;
    logic [2:0] seq_reg = 3'h0;
    logic ce_reg = 1'b1;
    logic dirty_reg = 1'b0;
    logic pend_reg = 1'b0;
    logic as_reg = 1'b1;
    int busy_reg = 0;
    int store_cnt = 0;
    // supply counts as low for the first cycles; the latched recall waits for it
    logic recall_pend = 1'b1;
    int low_cnt = 4;
    wire start = !mem_ce_n && ce_reg;
    wire hit = start && seq_reg == SEQ_LAST;
    // released bus flips each cycle so a stale byte never looks valid
    assign dq_in = (!mem_oe_n && start == 0 && !mem_ce_n && busy_reg == 0)
        ? sram[mem_addr] : ~last_reg;
    assign busy_drive = busy_reg != 0;
    // accesses counted on the falling chip select only
    always @(posedge mclk)
    begin
        ce_reg <= mem_ce_n;
        last_reg <= dq_in;
        if (host_pull && dirty_reg && low_cnt == 0)
            pend_reg <= 1'b1;
        if (low_cnt != 0)
        begin
            low_cnt <= low_cnt - 1;
            as_reg <= 1'b1;
        end
        else if (recall_pend)
        begin
            sram = nv;
            recall_pend <= 1'b0;
        end
        else if (busy_reg != 0)
            busy_reg <= busy_reg - 1;
        else if ((!host_pull && pend_reg) || (hit && mem_addr[15:0] == SEQ_STORE[15:0]))
        begin
            nv = sram;
            pend_reg <= 1'b0;
            seq_reg <= 3'h0;
            store_cnt <= store_cnt + 1;
            dirty_reg <= 1'b0;
            busy_reg <= BUSY_CYC;
        end
        else if (start && !mem_we_n)
        begin
            seq_reg <= 3'h0;
            if (!host_pull)
            begin
                sram[mem_addr] = dq_out;
                dirty_reg <= 1'b1;
            end
        end
        else if (start && !hit)
            seq_reg <= (mem_addr[15:0] == LEADS[16*seq_reg +: 16]) ? seq_reg + 3'h1 : 3'h0;
        else if (hit)
        begin
            seq_reg <= 3'h0;
            if (mem_addr[15:0] == SEQ_RECALL[15:0])
            begin
                sram = nv;
                dirty_reg <= 1'b0;
            end
            if (mem_addr[15:0] == SEQ_AS_OFF[15:0] || mem_addr[15:0] == SEQ_AS_ON[15:0])
                as_reg <= mem_addr[15:0] == SEQ_AS_ON[15:0];
        end
    end
endmodule

// file: nsrc_tb.sv
`timescale 1ns/1ps
module testbench;
    import nsrc_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic want = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] seed = 32'h2943;
    logic [31:0] prdata, rdat;
    logic pready, pslverr, mem_ce_n, mem_oe_n, mem_we_n, dq_oe, pin_out, pin_oe, busy_drive;
    logic [19:0] mem_addr, a;
    logic [7:0] dq_in, dq_out, d;
    logic [32:0] exp_q [$];
    logic [32:0] mask_q [$];
    int num_errors = 0;
    int check_count = 0;
    int st;
    // open-drain pin: low if anyone pulls, pull-up otherwise
    wire pin = ~((pin_oe & ~pin_out) | busy_drive);
    nsrc_host #(.GRACE_CYC(8), .STORE_CYC(40), .RECALL_CYC(20), .HW_RECALL_CYC(4)) i_nsrc_host (
        .mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .mem_addr, .mem_ce_n, .mem_oe_n, .mem_we_n, .dq_in, .dq_out, .dq_oe,
        .store_request_busy_n_in(pin), .store_request_busy_n_out(pin_out),
        .store_request_busy_n_oe(pin_oe));
    nsrc_dev_model i_nsrc_dev_model (.mclk, .mem_addr, .mem_ce_n, .mem_oe_n,
        .mem_we_n, .dq_out, .host_pull(pin_oe), .dq_in, .busy_drive);
    // free-running bench clock
    always #25 mclk = ~mclk;
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
        check_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer, held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] dt, input logic c);
        @(posedge mclk);
        want <= c;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= dt;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1)
            @(posedge mclk);
        rdat = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        want <= 1'b0;
    endtask
    task automatic chk(input logic [7:0] ad, input logic [32:0] e, input logic [32:0] m);
        exp_q.push_back(e);
        mask_q.push_back(m);
        apb(1'b0, ad, 32'h0, 1'b1);
    endtask
    task automatic op(input nsrc_cmd_t c, input logic [19:0] ad, input logic [7:0] dt);
        apb(1'b1, OFF_ADDR, {12'h0, ad}, 1'b0);
        apb(1'b1, OFF_WDATA, {24'h0, dt}, 1'b0);
        apb(1'b1, OFF_CTRL, {29'h0, c}, 1'b0);
        rdat = 32'h1;
        while (rdat[1:0] !== 2'b00)
            apb(1'b0, OFF_STATUS, 32'h0, 1'b0);
    endtask
    // read answers are matched against the oldest note
    always @(posedge mclk)
    begin
        if (want && psel && penable && pready === 1'b1)
            cmp({pslverr, prdata} & mask_q.pop_front(), exp_q.pop_front());
    end
    // hang guard, well above the whole run
    initial
    begin
        repeat (20000) @(posedge mclk);
        num_errors++;
        close_out();
    end
    initial
    begin
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        repeat (8) @(posedge mclk);
        chk(OFF_STATUS, 33'h08, 33'h1_0000_001f);
        chk(8'h14, 33'h1_0000_0000, '1);
        for (int i = 0; i < 4; i++)
        begin
            a = 20'(rnd());
            d = 8'(rnd());
            op(CMD_WRITE, a, d);
            op(CMD_READ, a, 8'h00);
            chk(OFF_RDATA, {25'h0, d}, '1);
        end
        chk(OFF_STATUS, 33'h4, 33'h4);
        $display("test read_write done");
        st = i_nsrc_dev_model.store_cnt;
        op(CMD_SW_STORE, 20'h0, 8'h00);
        cmp(33'(i_nsrc_dev_model.store_cnt), 33'(st + 1));
        op(CMD_WRITE, a, ~d);
        op(CMD_SW_RECALL, 20'h0, 8'h00);
        op(CMD_READ, a, 8'h00);
        chk(OFF_RDATA, {25'h0, d}, '1);
        $display("test store_recall done");
        op(CMD_AS_DISABLE, 20'h0, 8'h00);
        chk(OFF_STATUS, 33'h0, 33'h8);
        cmp(33'(i_nsrc_dev_model.as_reg), 33'h0);
        op(CMD_AS_ENABLE, 20'h0, 8'h00);
        chk(OFF_STATUS, 33'h8, 33'h8);
        cmp(33'(i_nsrc_dev_model.as_reg), 33'h1);
        $display("test autostore done");
        op(CMD_WRITE, a, d);
        op(CMD_HW_STORE, 20'h0, 8'h00);
        cmp(33'(i_nsrc_dev_model.store_cnt), 33'(st + 2));
        chk(OFF_STATUS, 33'h0, 33'h4);
        op(CMD_HW_STORE, 20'h0, 8'h00);
        cmp(33'(i_nsrc_dev_model.store_cnt), 33'(st + 2));
        $display("test hw_store done");
        apb(1'b1, OFF_CTRL, {29'h0, CMD_SW_STORE}, 1'b0);
        apb(1'b1, OFF_CTRL, {29'h0, CMD_READ}, 1'b0);
        op(CMD_NONE, 20'h0, 8'h00);
        cmp(33'(i_nsrc_dev_model.store_cnt), 33'(st + 3));
        chk(OFF_STATUS, 33'h18, 33'h1f);
        apb(1'b1, OFF_STATUS, 32'h10, 1'b0);
        chk(OFF_STATUS, 33'h08, 33'h1f);
        $display("test reject done");
        close_out();
    end
endmodule
